/* verilog/hbp_pkg.sv */
// Purpose: Constants, types and helpers of the host parallel port.
// Assumes: One 125 MHz clock, byte addresses on the internal side.
// Notes: Operation
// Operation
// [R1] Software picks each control line polarity.
// [R2] Demux byte order follows the endianness pin.
// [R3] Indexed byte order follows host config bit.
// [R4] Direction plus strobe replaces read/write strobes.
// [R5] Direction low reads, high writes; polarities programmable.
// [R6] Host stays in one dword until complete.
// [R7] Host gives address with strobes, no latch.
// [R8] Read data driven while read strobe active.
// [R9] 16-bit write captured at trailing strobe edge.
// [R10] 8-bit mode uses only the low lanes.
// [R11] Host config reached lower part first.
// [R12] Index register written lower part first.
// [R13] Index upper byte ignored, reads zero.
// [R14] Data register reaches address in its index.
// [R15] Host repeats full accesses without reindexing.
// [R16] Some internal addresses accept single partials.
// [R17] Writes commit whole; reads latch on first.
package hbp_pkg;
   // Widths of pins and the internal side
   localparam int HW = 16;
   localparam int AW = 16;
   localparam int IW = 24;
   localparam int SAW = 4;
   localparam int PIN_W = 36;
   // Software port offsets
   localparam logic [3:0] SW_CFG = 4'h0;
   localparam logic [3:0] SW_STAT = 4'h4;
   // Process interface config fields and reset value
   localparam int CFG_RWMODE = 0;
   localparam int CFG_CSPOL = 1;
   localparam int CFG_RDPOL = 2;
   localparam int CFG_WRPOL = 3;
   localparam int CFG_STALLPOL = 4;
   localparam int CFG_BUS16 = 5;
   localparam int CFG_INDEXED = 6;
   localparam logic [31:0] CFG_RST = 32'h0000_002E;
   // Host port config, kept in the indexed window
   localparam int HCFG_BIG = 0;
   localparam logic [31:0] HCFG_RST = 32'h0000_0000;
   // Indexed window address bits
   localparam int A_CFG = 4;
   localparam int A_PAIR = 3;
   localparam int A_DATA = 2;
   localparam logic [3:0] MASK_NONE = 4'h0;
   localparam logic [3:0] MASK_FULL = 4'hF;
   // Internal addresses that accept a lone partial access
   localparam logic [IW-1:0] SINGLE_LO = 24'h00_0100;
   localparam logic [IW-1:0] SINGLE_HI = 24'h00_01FF;

   typedef enum logic {HBP_IDLE, HBP_FETCH} hbp_state_t;

   // Byte lane of a host byte offset under the chosen order
   function automatic logic [1:0] hbp_lane(input logic [1:0] off,
                                           input logic big);
      return big ? ~off : off;
   endfunction : hbp_lane

   // Exempt window test
   function automatic logic hbp_single(input logic [IW-1:0] a);
      return (a >= SINGLE_LO) && (a <= SINGLE_HI);
   endfunction : hbp_single
endpackage : hbp_pkg

/* verilog/hbp_sync.sv */
// Purpose: Two-stage synchroniser for the host pins.
// Assumes: Pins are quasi-static around each strobe edge.
// Notes: Stage one feeds stage two only.
`timescale 1ns/1ps
module hbp_sync #(parameter int W = 1) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Pins in, synchronised out
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta;

   // Double flop against metastability
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta <= '0;
         q_out <= '0;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule : hbp_sync

/* verilog/hbp_merge.sv */
// Purpose: Byte lane steering between host lanes and a dword.
// Assumes: Offset is the host byte offset inside the dword.
// Notes: Purely combinational.
`timescale 1ns/1ps
module hbp_merge (
   // Dword and host data
   input wire logic [31:0] src_in,
   input wire logic [hbp_pkg::HW-1:0] hdata_in,
   // Access shape
   input wire logic [1:0] off_in,
   input wire logic bus16_in,
   input wire logic big_in,
   // Results
   output logic [31:0] merged_out,
   output logic [3:0] mask_out,
   output logic [hbp_pkg::HW-1:0] rdata_out
);
   import hbp_pkg::*;
   logic [1:0] off0;
   logic [1:0] lane0;
   logic [1:0] lane1;

   // Lane choice; a 16-bit access is word aligned
   assign off0 = bus16_in ? {off_in[1], 1'b0} : off_in; // R10
   assign lane0 = hbp_lane(off0, big_in); // R2 R3
   assign lane1 = hbp_lane({off_in[1], 1'b1}, big_in); // R2 R3

   // Steering; upper lanes unused in 8-bit mode
   always_comb begin
      merged_out = src_in;
      mask_out = MASK_NONE;
      merged_out[lane0*8 +: 8] = hdata_in[7:0];
      mask_out[lane0] = 1'b1;
      rdata_out = {8'h00, src_in[lane0*8 +: 8]};
      if (bus16_in) begin
         merged_out[lane1*8 +: 8] = hdata_in[15:8];
         mask_out[lane1] = 1'b1;
         rdata_out[15:8] = src_in[lane1*8 +: 8];
      end
   end
endmodule : hbp_merge

/* verilog/hbp_port.sv */
// Purpose: Demultiplexed and indexed host parallel port.
// Assumes: Internal read data stands within the cycle of the read pulse.
// Notes: Out of reset the port never stalls and the stall pin rests inactive; reset drives it low.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module hbp_port (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Host pins
   input wire logic host_cs_in,
   input wire logic host_rd_in,
   input wire logic host_wr_in,
   input wire logic host_end_in,
   input wire logic [hbp_pkg::AW-1:0] host_addr_in,
   input wire logic [hbp_pkg::HW-1:0] host_data_in,
   output logic [hbp_pkg::HW-1:0] host_data_out,
   output logic [1:0] host_data_oe_out,
   output logic host_wait_out,
   // Software register port
   input wire logic [hbp_pkg::SAW-1:0] sw_addr_in,
   input wire logic [31:0] sw_wdata_in,
   input wire logic sw_wr_in,
   input wire logic sw_rd_in,
   output logic [31:0] sw_rdata_out,
   // Internal access side
   output logic [hbp_pkg::IW-1:0] int_addr_out,
   output logic [31:0] int_wdata_out,
   output logic [3:0] int_be_out,
   output logic int_wr_out,
   output logic int_rd_out,
   input wire logic [31:0] int_rdata_in
);
   import hbp_pkg::*;

   logic [PIN_W-1:0] pin_s;
   logic [31:0] cfg;
   logic [31:0] hcfg;
   logic [31:0] rlatch;
   logic [31:0] wbuf;
   logic [IW-1:0] idx [2];
   logic [IW-1:0] cur_addr;
   logic [3:0] wmask;
   logic [3:0] rmask;
   logic rd_q;
   logic wr_q;
   logic [AW-1:0] acc_addr;
   logic [HW-1:0] acc_data;
   logic acc_end;
   hbp_state_t st;

   // Every pin is synchronised before any logic sees it
   hbp_sync #(.W(PIN_W)) u_sync (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .d_in({host_cs_in, host_rd_in, host_wr_in, host_end_in,
             host_addr_in, host_data_in}),
      .q_out(pin_s)
   );

   // Pin fields
   wire cs_s = pin_s[35];
   wire dir_s = pin_s[34];
   wire stb_s = pin_s[33];
   wire end_s = pin_s[32];
   wire [AW-1:0] addr_s = pin_s[31:16];
   wire [HW-1:0] hd_s = pin_s[15:0];

   // Polarity and control scheme decode
   wire cs_a = cs_s ~^ cfg[CFG_CSPOL]; // R1
   wire rd_lvl = dir_s ~^ cfg[CFG_RDPOL]; // R1 R5
   wire wr_lvl = stb_s ~^ cfg[CFG_WRPOL]; // R1 R5
   wire rw_mode = cfg[CFG_RWMODE];
   wire rd_act = cs_a & (rw_mode ? (wr_lvl & ~rd_lvl) : rd_lvl); // R4 R5
   wire wr_act = cs_a & (rw_mode ? (wr_lvl & rd_lvl) : wr_lvl); // R4 R5
   wire rd_rise = rd_act & ~rd_q;
   wire wr_fall = wr_q & ~wr_act; // R9 R10
   wire indexed = cfg[CFG_INDEXED];
   wire bus16 = cfg[CFG_BUS16];
   wire cfg_wr = sw_wr_in && (sw_addr_in == SW_CFG);

   // Access decode; writes use what stood during the strobe
   wire [AW-1:0] ea = wr_fall ? acc_addr : addr_s; // R7
   wire ee = wr_fall ? acc_end : end_s; // R2
   wire pair = ea[A_PAIR];
   wire sel_cfg = indexed & ea[A_CFG];
   wire sel_idx = indexed & ~ea[A_CFG] & ~ea[A_DATA];
   wire sel_data = ~sel_cfg & ~sel_idx;
   wire big = indexed ? hcfg[HCFG_BIG] : ee; // R2 R3
   wire [IW-1:0] idx_sel = idx[pair];
   wire [IW-1:0] tgt = indexed ? {idx_sel[IW-1:2], 2'b00}
                               : {8'h00, ea[AW-1:2], 2'b00}; // R14
   wire same = (tgt == cur_addr);
   wire single = hbp_single(tgt); // R16

   // Source dword of the steering network
   wire [31:0] msrc = (st == HBP_FETCH) ? int_rdata_in :
                      sel_cfg ? hcfg :
                      sel_idx ? {8'h00, idx_sel} :
                      wr_fall ? wbuf : rlatch;
   wire [31:0] m_word;
   wire [3:0] m_mask;
   wire [HW-1:0] m_half;

   hbp_merge u_merge (
      .src_in(msrc),
      .hdata_in(acc_data),
      .off_in(ea[1:0]),
      .bus16_in(bus16),
      .big_in(big),
      .merged_out(m_word),
      .mask_out(m_mask),
      .rdata_out(m_half)
   );

   // Part tracking of the current dword
   wire [3:0] wnew = (same ? wmask : MASK_NONE) | m_mask;
   wire wdone = (wnew == MASK_FULL) | single; // R16 R17
   wire rhit = same & (rmask != MASK_NONE);
   wire [3:0] rnew = (rhit ? rmask : MASK_NONE) | m_mask;
   wire rdone = (rnew == MASK_FULL) | single; // R16 R17
   wire [31:0] stat = {23'h00_0000, st == HBP_FETCH, rmask, wmask};

   // Strobe history and values captured while the write strobe stands
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         acc_addr <= '0;
         acc_data <= '0;
         acc_end <= 1'b0;
      end else begin
         rd_q <= rd_act;
         wr_q <= wr_act;
         if (wr_act) begin
            acc_addr <= addr_s;
            acc_data <= hd_s; // R9
            acc_end <= end_s; // R2
         end
      end
   end

   // Software port: config write, one-cycle read answer
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg <= CFG_RST;
         sw_rdata_out <= '0;
      end else begin
         if (cfg_wr) begin
            cfg <= sw_wdata_in; // R1
         end
         sw_rdata_out <= !sw_rd_in ? 32'h0000_0000 :
                         (sw_addr_in == SW_CFG) ? cfg :
                         (sw_addr_in == SW_STAT) ? stat : 32'h0000_0000;
      end
   end

   // Pin drive; the stall line shows the configured idle level one cycle later; reset drives it low
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         host_data_oe_out <= 2'b00;
         host_wait_out <= 1'b0;
      end else begin
         host_data_oe_out <= rd_act ? {bus16, 1'b1} : 2'b00; // R8 R10
         host_wait_out <= ~cfg[CFG_STALLPOL]; // R1
      end
   end

   // Writes to the host config and index registers
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hcfg <= HCFG_RST;
         idx[0] <= '0;
         idx[1] <= '0;
      end else if (wr_fall && sel_cfg) begin
         hcfg <= m_word; // R3
      end else if (wr_fall && sel_idx) begin
         idx[pair] <= m_word[IW-1:0]; // R13
      end
   end

   // Data path: write assembly, read fetch and latch.
   // A write to the dword drops the read latch, so a later read
   // never returns data older than the host's last whole write; parts still held in wbuf are not in it.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= HBP_IDLE;
         cur_addr <= '0;
         wmask <= MASK_NONE;
         rmask <= MASK_NONE;
         wbuf <= '0;
         rlatch <= '0;
         host_data_out <= '0;
         int_addr_out <= '0;
         int_wdata_out <= '0;
         int_be_out <= MASK_NONE;
         int_wr_out <= 1'b0;
         int_rd_out <= 1'b0;
      end else begin
         int_wr_out <= 1'b0;
         int_rd_out <= 1'b0;
         if (st == HBP_FETCH) begin
            rlatch <= int_rdata_in; // R17
            host_data_out <= m_half; // R8
            rmask <= rdone ? MASK_NONE : rnew;
            st <= HBP_IDLE;
         end else if (wr_fall && sel_data) begin
            cur_addr <= tgt;
            rmask <= MASK_NONE;
            if (wdone) begin
               int_wr_out <= 1'b1; // R17
               int_addr_out <= tgt; // R14
               int_wdata_out <= m_word;
               int_be_out <= wnew;
               wmask <= MASK_NONE;
            end else begin
               wbuf <= m_word; // R17
               wmask <= wnew;
            end
         end else if (rd_rise && sel_data && !rhit) begin
            int_rd_out <= 1'b1; // R14 R17
            int_addr_out <= tgt;
            cur_addr <= tgt;
            rmask <= MASK_NONE;
            st <= HBP_FETCH;
         end else if (rd_rise) begin
            host_data_out <= m_half; // R8
            if (sel_data) begin
               rmask <= rdone ? MASK_NONE : rnew; // R17
            end
         end
         // A width change must not leave old upper lanes showing
         if (cfg_wr) begin
            host_data_out <= '0; // R10
         end
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   property p_oe_read;
      rd_act |=> host_data_oe_out[0];
   endproperty
   a_oe_read: assert property (p_oe_read) // R8
      else $error("read data not driven during read strobe");

   property p_oe_idle;
      !rd_act |=> host_data_oe_out == 2'b00;
   endproperty
   a_oe_idle: assert property (p_oe_idle) // R8
      else $error("data driven without read strobe");

   property p_narrow;
      !bus16 |-> !host_data_oe_out[1] && host_data_out[15:8] == 8'h00;
   endproperty
   a_narrow: assert property (p_narrow) // R10
      else $error("upper lanes used in 8-bit mode");

   property p_commit_cause;
      int_wr_out |-> $past(wr_fall) && $past(sel_data);
   endproperty
   a_commit_cause: assert property (p_commit_cause) // R9
      else $error("internal write without trailing strobe edge");

   property p_commit_whole;
      int_wr_out && !hbp_single(int_addr_out) |-> int_be_out == MASK_FULL;
   endproperty
   a_commit_whole: assert property (p_commit_whole) // R17
      else $error("partial internal write outside exempt window");

   property p_fetch_once;
      int_rd_out |=> !int_rd_out ##1 st == HBP_IDLE;
   endproperty
   a_fetch_once: assert property (p_fetch_once) // R17
      else $error("internal read repeated or fetch stuck");

   property p_fetch_addr;
      int_rd_out |-> indexed ? int_addr_out[IW-1:2] == idx_sel[IW-1:2]
                             : int_addr_out[AW-1:2] == ea[AW-1:2];
   endproperty
   a_fetch_addr: assert property (p_fetch_addr) // R14
      else $error("internal read at wrong address");

   property p_stall_idle;
      !$past(rst_in) |-> host_wait_out == ~$past(cfg[CFG_STALLPOL]);
   endproperty
   a_stall_idle: assert property (p_stall_idle) // R1
      else $error("stall line not at its idle level");

   property p_sw_read;
      sw_rd_in && sw_addr_in == SW_CFG |=> sw_rdata_out == $past(cfg);
   endproperty
   a_sw_read: assert property (p_sw_read) // R1
      else $error("config readback mismatch");

   property p_idx_upper;
      wr_fall && sel_idx |=> idx[$past(pair)] == $past(m_word[IW-1:0]);
   endproperty
   a_idx_upper: assert property (p_idx_upper) // R13
      else $error("index register write lost");

   c_commit: cover property (int_wr_out && int_be_out == MASK_FULL);
   c_fetch: cover property (int_rd_out ##2 rd_rise && rhit);
   c_rwmode: cover property (rw_mode && wr_fall);
   c_big: cover property (indexed && hcfg[HCFG_BIG] && int_wr_out);
endmodule : hbp_port

/* sim/hbp_mem_model.sv */
// Purpose: Internal memory seen behind the host parallel port.
// Assumes: Read data wanted within the cycle of the read pulse.
// Notes: Off-cycle read data toggles so stale values never match.
`timescale 1ns/1ps
module hbp_mem_model (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Internal access from the port
   input wire logic [23:0] int_addr_in,
   input wire logic [31:0] int_wdata_in,
   input wire logic [3:0] int_be_in,
   input wire logic int_wr_in,
   input wire logic int_rd_in,
   output logic [31:0] int_rdata_out,
   // Bookkeeping for the bench
   output logic [7:0] wr_count_out,
   output logic [7:0] rd_count_out,
   output logic [23:0] last_addr_out,
   output logic [3:0] last_be_out
);
   logic [31:0] mem [0:127];
   wire [6:0] idx = int_addr_in[8:2];
   logic [31:0] junk;

   // Port samples the answer at the edge that ends its read pulse
   assign int_rdata_out = int_rd_in ? mem[idx] : junk;

   // Known start pattern, word index in the low bits
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 32'hA5A5_0000 + i;
   end

   // Addressed location served; lanes written by enable
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         junk <= 32'h0000_0000;
         wr_count_out <= 8'h00;
         rd_count_out <= 8'h00;
         last_addr_out <= 24'h00_0000;
         last_be_out <= 4'h0;
      end else begin
         if (int_wr_in) begin
            for (int b = 0; b < 4; b++) begin
               if (int_be_in[b]) mem[idx][8*b +: 8] <= int_wdata_in[8*b +: 8];
            end
            wr_count_out <= wr_count_out + 8'h01;
            last_addr_out <= int_addr_in;
            last_be_out <= int_be_in;
         end
         if (int_rd_in) begin
            rd_count_out <= rd_count_out + 8'h01;
         end
         junk <= ~junk;
      end
   end
endmodule : hbp_mem_model

/* sim/hbp_port_tb.sv */
// Purpose: Self-checking bench for the host parallel port.
// Assumes: Internal side served by hbp_mem_model.
// Notes: Eight-clock strobes cover the two-flop pin lag.
`timescale 1ns/1ps
module hbp_port_tb;
   import hbp_pkg::*;
   // Pins, software port and model taps
   logic sys_clk_in = 0;
   logic rst_in = 1;
   logic host_cs_in = 0, host_rd_in = 0, host_wr_in = 0;
   logic host_end_in = 0;
   logic [AW-1:0] host_addr_in = '0;
   logic [HW-1:0] host_data_in = '0, host_data_out;
   logic [1:0] host_data_oe_out;
   logic host_wait_out, sw_wr_in = 0, sw_rd_in = 0;
   logic [SAW-1:0] sw_addr_in = '0;
   logic [31:0] sw_wdata_in = '0, sw_rdata_out, int_wdata_out;
   logic [31:0] int_rdata_in, v;
   logic int_wr_out, int_rd_out;
   logic [IW-1:0] int_addr_out, last_addr;
   logic [3:0] int_be_out, last_be;
   logic [7:0] wr_cnt, rd_cnt;
   logic cs_p, rd_p, wr_p, rw_m, b16;
   int err_count = 0, samples_checked = 0;

   // 125 MHz clock
   always #4 sys_clk_in = ~sys_clk_in;

   hbp_port uut (.sys_clk_in, .rst_in, .host_cs_in, .host_rd_in,
      .host_wr_in, .host_end_in, .host_addr_in, .host_data_in,
      .host_data_out, .host_data_oe_out, .host_wait_out, .sw_addr_in,
      .sw_wdata_in, .sw_wr_in, .sw_rd_in, .sw_rdata_out, .int_addr_out,
      .int_wdata_out, .int_be_out, .int_wr_out, .int_rd_out,
      .int_rdata_in);

   hbp_mem_model mem (.sys_clk_in, .rst_in, .int_addr_in(int_addr_out),
      .int_wdata_in(int_wdata_out), .int_be_in(int_be_out),
      .int_wr_in(int_wr_out), .int_rd_in(int_rd_out),
      .int_rdata_out(int_rdata_in), .wr_count_out(wr_cnt),
      .rd_count_out(rd_cnt), .last_addr_out(last_addr),
      .last_be_out(last_be));

   task automatic results();
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk

   task automatic sw_w(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      sw_addr_in <= a;
      sw_wdata_in <= d;
      sw_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      sw_wr_in <= 1'b0;
   endtask : sw_w

   // Read data only stands in the cycle after the strobe
   task automatic sw_r(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      sw_addr_in <= a;
      sw_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      sw_rd_in <= 1'b0;
      #1 d = sw_rdata_out;
   endtask : sw_r

   // Direction stays put so a trailing write edge keeps its sense
   task automatic idle();
      host_cs_in <= ~cs_p;
      host_wr_in <= ~wr_p;
      if (!rw_m) host_rd_in <= ~rd_p;
   endtask : idle

   task automatic setcfg(input logic [31:0] c);
      sw_w(SW_CFG, c);
      {b16, wr_p, rd_p} = {c[CFG_BUS16], c[CFG_WRPOL], c[CFG_RDPOL]};
      {cs_p, rw_m} = {c[CFG_CSPOL], c[CFG_RWMODE]};
      idle();
      repeat (4) @(posedge sys_clk_in);
   endtask : setcfg

   // One host cycle, strobe held eight clocks, gap of six
   task automatic hx(input logic w, input logic [15:0] a, d,
                     output logic [15:0] r);
      @(posedge sys_clk_in);
      host_cs_in <= cs_p;
      host_addr_in <= a;
      host_data_in <= d;
      if (rw_m) begin
         host_rd_in <= w ~^ rd_p;
         host_wr_in <= wr_p;
      end else if (w) begin
         host_wr_in <= wr_p;
      end else begin
         host_rd_in <= rd_p;
      end
      repeat (7) @(posedge sys_clk_in);
      #1 r = host_data_out;
      if (!w) chk(32'(host_data_oe_out), b16 ? 3 : 1);
      @(posedge sys_clk_in);
      idle();
      @(posedge sys_clk_in);
      host_data_in <= ~d;
      repeat (4) @(posedge sys_clk_in);
   endtask : hx

   // Whole dword, parts in address order; upper lanes junk in 8-bit
   task automatic wd(input logic [15:0] a, input logic [31:0] d);
      logic [15:0] r;
      for (int i = 0; i < (b16 ? 2 : 4); i++) begin
         if (b16) hx(1, a + 16'(2 * i), d[16*i +: 16], r);
         else hx(1, a + 16'(i), {8'hC3, d[8*i +: 8]}, r);
      end
   endtask : wd

   task automatic rdd(input logic [15:0] a, output logic [31:0] d);
      logic [15:0] r;
      for (int i = 0; i < (b16 ? 2 : 4); i++) begin
         if (b16) begin
            hx(0, a + 16'(2 * i), 16'h5A5A, r);
            d[16*i +: 16] = r;
         end else begin
            hx(0, a + 16'(i), 16'h5A5A, r);
            d[8*i +: 8] = r[7:0];
            chk(32'(r[15:8]), 0);
         end
      end
      chk(32'(host_data_oe_out), 0);
   endtask : rdd

   // Hang guard
   initial begin
      repeat (90000) @(posedge sys_clk_in);
      err_count++;
      results();
   end

   initial begin
      repeat (16) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      sw_r(SW_CFG, v);
      chk(v, CFG_RST);
      chk(32'(host_wait_out), 1);
      sw_r(4'h8, v);
      chk(v, 0);
      sw_w(SW_STAT, 32'hFFFF_FFFF);
      sw_r(SW_STAT, v);
      chk(v, 0);
      setcfg(CFG_RST);
      wd(16'h0010, 32'hCAFE_1234);
      chk(32'(wr_cnt), 1);
      chk(32'(last_be), 32'(MASK_FULL));
      rdd(16'h0010, v);
      chk(v, 32'hCAFE_1234);
      chk(32'(rd_cnt), 1);
      rdd(16'h0030, v);
      chk(v, 32'hA5A5_000C);
      hx(1, 16'h0100, 16'h7788, v[15:0]);
      chk(32'(wr_cnt), 2);
      chk(32'(last_be), 4'h3);
      // 8-bit, big order from the pin, read back little
      setcfg(32'h0000_000E);
      host_end_in <= 1'b1;
      wd(16'h0020, 32'h4433_2211);
      rdd(16'h0020, v);
      chk(v, 32'h4433_2211);
      host_end_in <= 1'b0;
      rdd(16'h0020, v);
      chk(v, 32'h1122_3344);
      // Indexed 16-bit: index upper byte dropped
      setcfg(32'h0000_006E);
      wd(16'h0000, 32'hAB00_0040);
      rdd(16'h0000, v);
      chk(v, 32'h0000_0040);
      wd(16'h0004, 32'h1357_9BDF);
      chk(32'(last_addr), 32'h0000_0040);
      rdd(16'h0004, v);
      chk(v, 32'h1357_9BDF);
      rdd(16'h0004, v);
      chk(32'(rd_cnt), 6);
      wd(16'h0008, 32'h0000_0050);
      rdd(16'h000C, v);
      chk(v, 32'hA5A5_0014);
      // Indexed 8-bit, big order from the host config bit
      setcfg(32'h0000_004E);
      hx(1, 16'h0010, 16'h0001, v[15:0]);
      wd(16'h000C, 32'h4433_2211);
      // Big order puts the flag byte at offset three
      hx(1, 16'h0013, 16'h0000, v[15:0]);
      rdd(16'h000C, v);
      chk(v, 32'h1122_3344);
      // Direction and enable, select and enable active low
      setcfg(32'h0000_0035);
      chk(32'(host_wait_out), 0);
      wd(16'h0030, 32'h0BAD_F00D);
      chk(32'(last_addr), 32'h0000_0030);
      rdd(16'h0030, v);
      chk(v, 32'h0BAD_F00D);
      results();
   end
endmodule : hbp_port_tb
